// [rtl/dhg_defines.svh]
// offsets, field positions, reset values for the shared-pin block
// What this block does
// - 24 shared pins in three groups of eight, one owner-select bit per group.
// - host owner with main power bad: whole group tristated as input.
// - host owner with power good: pin direction follows host direction bit.
// - micro owner: pin direction follows micro direction bit, power ignored.
// - output level comes from the selected owner's output register.
// - micro input registers always return live pin states.
// - group zero input pins raise an event on both edges.
// - separate host and micro direction and output register sets.
// - micro selects open-drain or push-pull on sixteen pins.
// - owner-select and buffer type writable only from micro side.
// - activate bit zero gates host window decoding.
// - base from index 0x60 low nibble and index 0x61 byte.
// - window holds direction, input, output per group at offsets 0 to 8.
// - host window access works whatever the owner-select bits say.
`ifndef DHG_DEFINES_SVH
`define DHG_DEFINES_SVH

// ---------------------------------------------------------------
// configuration indexes
// ---------------------------------------------------------------
`define DHG_CFG_ACTIVATE    8'h30
`define DHG_CFG_BASE_HIGH   8'h60
`define DHG_CFG_BASE_LOW    8'h61
`define DHG_ACTIVATE_BIT    0
`define DHG_CFG_RESET       8'h00

// ---------------------------------------------------------------
// host window layout: stride of three per group
// ---------------------------------------------------------------
`define DHG_WIN_STRIDE      4'h3
`define DHG_WIN_DIR         4'h0
`define DHG_WIN_IN          4'h1
`define DHG_WIN_OUT         4'h2
`define DHG_WIN_LAST        4'h8

// ---------------------------------------------------------------
// micro-side register indexes
// ---------------------------------------------------------------
`define DHG_MC_OWNER        4'h0
`define DHG_MC_DIR0         4'h1
`define DHG_MC_OUT0         4'h4
`define DHG_MC_IN0          4'h7
`define DHG_MC_BUF0         4'hA
`define DHG_MC_BUF1         4'hB
`define DHG_REG_RESET       8'h00

`endif

// [rtl/dhg_pkg.sv]
// shared types of the shared-pin block
package dhg_pkg;
    typedef logic [7:0]      dhg_byte_t;
    typedef logic [2:0][7:0] dhg_bank_t;
    typedef enum logic { DHG_OWNER_MICRO, DHG_OWNER_HOST } dhg_owner_e;
endpackage

// [rtl/dhg_group_if.sv]
// per-group control bundle between top and the resolver
`timescale 1ns/100ps
`default_nettype none
interface dhg_group_if;
    logic               owner_host;
    logic               power_good;
    dhg_pkg::dhg_byte_t host_dir;
    dhg_pkg::dhg_byte_t host_out;
    dhg_pkg::dhg_byte_t mc_dir;
    dhg_pkg::dhg_byte_t mc_out;
    dhg_pkg::dhg_byte_t pin_dir;
    dhg_pkg::dhg_byte_t pin_lvl;

    modport ctrl    (output owner_host, power_good, host_dir, host_out, mc_dir, mc_out,
                     input pin_dir, pin_lvl);
    modport resolve (input owner_host, power_good, host_dir, host_out, mc_dir, mc_out,
                     output pin_dir, pin_lvl);
endinterface
`default_nettype wire

// [rtl/dhg_group_resolve.sv]
// direction and level resolution for one group of eight pins
`timescale 1ns/100ps
`default_nettype none
module dhg_group_resolve
(
    // group bundle
    dhg_group_if.resolve grp
);
    // ---------------------------------------------------------------
    // owner and power decide who steers the pins
    // ---------------------------------------------------------------
    always_comb
    begin
        if (grp.owner_host && !grp.power_good)
        begin
            grp.pin_dir = 8'h00;
        end
        else if (grp.owner_host)
        begin
            grp.pin_dir = grp.host_dir;
        end
        else
        begin
            grp.pin_dir = grp.mc_dir;
        end
        grp.pin_lvl = grp.owner_host ? grp.host_out : grp.mc_out;
    end
endmodule
`default_nettype wire

// [rtl/dhg_shared_gpio.sv]
// shared host/micro general-purpose pin bank with host window decode
`include "dhg_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dhg_shared_gpio
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // power state of the main supply, asynchronous
    input  wire logic                 main_power_good,
    // configuration space access, already decoded to this unit
    input  wire logic                 cfg_wr,
    input  wire logic                 cfg_rd,
    input  wire logic [7:0]           cfg_index,
    input  wire logic [7:0]           cfg_wdata,
    output logic      [7:0]           cfg_rdata,
    // host i/o cycles
    input  wire logic                 io_wr,
    input  wire logic                 io_rd,
    input  wire logic [15:0]          io_addr,
    input  wire logic [7:0]           io_wdata,
    output logic      [7:0]           io_rdata,
    output logic                      io_hit,
    // micro register port
    input  wire logic                 mc_wr,
    input  wire logic                 mc_rd,
    input  wire logic [3:0]           mc_addr,
    input  wire logic [7:0]           mc_wdata,
    output logic      [7:0]           mc_rdata,
    // pins
    input  wire logic [23:0]          shared_host_pin_in,
    output logic      [23:0]          shared_host_pin_out,
    output logic      [23:0]          shared_host_pin_oe,
    // edge events of group zero
    output logic      [7:0]           pin_edge_event,
    output logic                      wake_event
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic               activate_reg,  activate_next;
    logic [3:0]         base_high_reg, base_high_next;
    logic [7:0]         base_low_reg,  base_low_next;
    dhg_pkg::dhg_bank_t host_dir_reg,  host_dir_next;
    dhg_pkg::dhg_bank_t host_out_reg,  host_out_next;
    dhg_pkg::dhg_bank_t mc_dir_reg,    mc_dir_next;
    dhg_pkg::dhg_bank_t mc_out_reg,    mc_out_next;
    logic [2:0]         owner_reg,     owner_next;
    logic [15:0]        buf_od_reg,    buf_od_next;
    logic [23:0]        pin_meta_reg,  pin_sync_reg,  pin_prev_reg;
    logic               pg_meta_reg,   pg_sync_reg;
    // edge warm-up: a one walks up while the sample chain refills after reset
    logic [2:0]         prime_reg,     prime_next;
    logic [7:0]         cfg_rdata_next, io_rdata_next, mc_rdata_next;
    logic               io_hit_next;
    logic [23:0]        pin_out_next,  pin_oe_next;
    logic [7:0]         edge_next;
    logic               wake_next;
    logic               win_hit;
    logic [3:0]         win_off;
    dhg_pkg::dhg_bank_t live_in;
    dhg_pkg::dhg_bank_t res_dir;
    dhg_pkg::dhg_bank_t res_lvl;
    logic [23:0]        od_full;

    dhg_group_if grp_bus [3] ();

    // ---------------------------------------------------------------
    // per-group resolvers
    // ---------------------------------------------------------------
    for (genvar g = 0; g < 3; g++)
    begin : g_grp
        assign grp_bus[g].owner_host = owner_reg[g];
        assign grp_bus[g].power_good = pg_sync_reg;
        assign grp_bus[g].host_dir   = host_dir_reg[g];
        assign grp_bus[g].host_out   = host_out_reg[g];
        assign grp_bus[g].mc_dir     = mc_dir_reg[g];
        assign grp_bus[g].mc_out     = mc_out_reg[g];
        assign res_dir[g]            = grp_bus[g].pin_dir;
        assign res_lvl[g]            = grp_bus[g].pin_lvl;
        assign live_in[g]            = pin_sync_reg[g*8 +: 8];
        dhg_group_resolve u_resolve
        (
            .grp (grp_bus[g])
        );
    end

    // only groups zero and one have a selectable buffer
    assign od_full = {8'h00, buf_od_reg};

    // ---------------------------------------------------------------
    // window decode: a hit needs activation and a base match
    // ---------------------------------------------------------------
    always_comb
    begin
        // base low nibble is kept for readback only; hosts keep it zero
        win_off = io_addr[3:0];
        win_hit = activate_reg && (io_addr[15:12] == 4'h0)
                  && (io_addr[11:8] == base_high_reg)
                  && (io_addr[7:4] == base_low_reg[7:4]);
    end

    // ---------------------------------------------------------------
    // next values for registers, read data, pins and events
    // ---------------------------------------------------------------
    always_comb
    begin
        activate_next  = activate_reg;
        base_high_next = base_high_reg;
        base_low_next  = base_low_reg;
        host_dir_next  = host_dir_reg;
        host_out_next  = host_out_reg;
        mc_dir_next    = mc_dir_reg;
        mc_out_next    = mc_out_reg;
        owner_next     = owner_reg;
        buf_od_next    = buf_od_reg;
        cfg_rdata_next = 8'h00;
        io_rdata_next  = 8'h00;
        mc_rdata_next  = 8'h00;
        io_hit_next    = (io_wr || io_rd) && win_hit;

        // configuration space writes and reads
        if (cfg_wr)
        begin
            unique case (cfg_index)
                `DHG_CFG_ACTIVATE:  activate_next  = cfg_wdata[`DHG_ACTIVATE_BIT];
                `DHG_CFG_BASE_HIGH: base_high_next = cfg_wdata[3:0];
                `DHG_CFG_BASE_LOW:  base_low_next  = cfg_wdata;
                default: ;
            endcase
        end
        if (cfg_rd)
        begin
            unique case (cfg_index)
                `DHG_CFG_ACTIVATE:  cfg_rdata_next = {7'h00, activate_reg};
                `DHG_CFG_BASE_HIGH: cfg_rdata_next = {4'h0, base_high_reg};
                `DHG_CFG_BASE_LOW:  cfg_rdata_next = base_low_reg;
                default:            cfg_rdata_next = 8'h00;
            endcase
        end

        // host window, owner bits play no part here
        for (int g = 0; g < 3; g++)
        begin
            if (win_hit && io_wr && win_off == 4'(g * 3) + `DHG_WIN_DIR)
            begin
                host_dir_next[g] = io_wdata;
            end
            if (win_hit && io_wr && win_off == 4'(g * 3) + `DHG_WIN_OUT)
            begin
                host_out_next[g] = io_wdata;
            end
            if (win_hit && io_rd && win_off == 4'(g * 3) + `DHG_WIN_DIR)
            begin
                io_rdata_next = host_dir_reg[g];
            end
            if (win_hit && io_rd && win_off == 4'(g * 3) + `DHG_WIN_IN)
            begin
                io_rdata_next = live_in[g];
            end
            if (win_hit && io_rd && win_off == 4'(g * 3) + `DHG_WIN_OUT)
            begin
                io_rdata_next = host_out_reg[g];
            end
        end

        // micro side: only path to owner and buffer bits
        for (int g = 0; g < 3; g++)
        begin
            if (mc_wr && mc_addr == `DHG_MC_DIR0 + 4'(g))
            begin
                mc_dir_next[g] = mc_wdata;
            end
            if (mc_wr && mc_addr == `DHG_MC_OUT0 + 4'(g))
            begin
                mc_out_next[g] = mc_wdata;
            end
            if (mc_rd && mc_addr == `DHG_MC_DIR0 + 4'(g))
            begin
                mc_rdata_next = mc_dir_reg[g];
            end
            if (mc_rd && mc_addr == `DHG_MC_OUT0 + 4'(g))
            begin
                mc_rdata_next = mc_out_reg[g];
            end
            if (mc_rd && mc_addr == `DHG_MC_IN0 + 4'(g))
            begin
                mc_rdata_next = live_in[g];
            end
        end
        if (mc_wr && mc_addr == `DHG_MC_OWNER)
        begin
            owner_next = mc_wdata[2:0];
        end
        if (mc_wr && mc_addr == `DHG_MC_BUF0)
        begin
            buf_od_next[7:0] = mc_wdata;
        end
        if (mc_wr && mc_addr == `DHG_MC_BUF1)
        begin
            buf_od_next[15:8] = mc_wdata;
        end
        if (mc_rd && mc_addr == `DHG_MC_OWNER)
        begin
            mc_rdata_next = {5'h00, owner_reg};
        end
        if (mc_rd && mc_addr == `DHG_MC_BUF0)
        begin
            mc_rdata_next = buf_od_reg[7:0];
        end
        if (mc_rd && mc_addr == `DHG_MC_BUF1)
        begin
            mc_rdata_next = buf_od_reg[15:8];
        end

        // open drain drives only low, releases for high
        pin_oe_next  = res_dir & ~(od_full & res_lvl);
        pin_out_next = res_lvl & ~od_full;

        // edge compare waits until the prior-sample flop holds a real level;
        // it resets low, so a pin idling high would fake an edge after reset
        prime_next = {prime_reg[1:0], 1'b1};

        // both edges on group zero inputs; a host group in power fail counts as input
        edge_next = (pin_sync_reg[7:0] ^ pin_prev_reg[7:0]) & ~res_dir[0]
                    & {8{prime_reg[2]}};
        wake_next = |edge_next;
    end

    // ---------------------------------------------------------------
    // register file, read data, pins and events
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            activate_reg        <= 1'b0;
            base_high_reg       <= 4'h0;
            base_low_reg        <= `DHG_CFG_RESET;
            host_dir_reg        <= '0;
            host_out_reg        <= '0;
            mc_dir_reg          <= '0;
            mc_out_reg          <= '0;
            owner_reg           <= 3'h0;
            buf_od_reg          <= 16'h0000;
            cfg_rdata           <= `DHG_REG_RESET;
            io_rdata            <= `DHG_REG_RESET;
            mc_rdata            <= `DHG_REG_RESET;
            io_hit              <= 1'b0;
            shared_host_pin_out <= 24'h000000;
            shared_host_pin_oe  <= 24'h000000;
            pin_edge_event      <= 8'h00;
            wake_event          <= 1'b0;
        end
        else
        begin
            activate_reg        <= activate_next;
            base_high_reg       <= base_high_next;
            base_low_reg        <= base_low_next;
            host_dir_reg        <= host_dir_next;
            host_out_reg        <= host_out_next;
            mc_dir_reg          <= mc_dir_next;
            mc_out_reg          <= mc_out_next;
            owner_reg           <= owner_next;
            buf_od_reg          <= buf_od_next;
            cfg_rdata           <= cfg_rdata_next;
            io_rdata            <= io_rdata_next;
            mc_rdata            <= mc_rdata_next;
            io_hit              <= io_hit_next;
            shared_host_pin_out <= pin_out_next;
            shared_host_pin_oe  <= pin_oe_next;
            pin_edge_event      <= edge_next;
            wake_event          <= wake_next;
        end
    end

    // ---------------------------------------------------------------
    // input synchronisers and edge warm-up
    // ---------------------------------------------------------------
    // only the second flop is read; the first may still be settling
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta_reg <= 24'h000000;
            pin_sync_reg <= 24'h000000;
            pin_prev_reg <= 24'h000000;
            pg_meta_reg  <= 1'b0;
            pg_sync_reg  <= 1'b0;
            prime_reg    <= 3'h0;
        end
        else
        begin
            pin_meta_reg <= shared_host_pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
            pg_meta_reg  <= main_power_good;
            pg_sync_reg  <= pg_meta_reg;
            prime_reg    <= prime_next;
        end
    end
endmodule
`default_nettype wire

// [dv/dhg_shared_gpio_assertions.sv]
// port-level checker for the shared-pin block
`timescale 1ns/100ps
`default_nettype none
module dhg_shared_gpio_checker
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // config and host io
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_index,
    input wire logic [7:0]  cfg_wdata,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_hit,
    // pins and events
    input wire logic [23:0] shared_host_pin_in,
    input wire logic [7:0]  pin_edge_event,
    input wire logic        wake_event
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic act_reg;
    logic act_next;
    // ----------------------------------------
    // shadow of the activate bit
    // ----------------------------------------
    always_comb act_next = (cfg_wr && cfg_index == 8'h30) ? cfg_wdata[0] : act_reg;
    always_ff @(posedge sys_clk or posedge rst)
        if (rst) act_reg <= 1'b0;
        else act_reg <= act_next;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_hit_cause; io_hit |-> $past(io_wr || io_rd); endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without strobe");
    property p_hit_act; io_hit |-> $past(act_reg); endproperty
    a_hit_act: assert property (p_hit_act) else $error("hit while window off");
    property p_hit_range; $past(io_addr[15:12]) != 4'h0 |-> !io_hit; endproperty
    a_hit_range: assert property (p_hit_range) else $error("hit above 0x0FFF");
    property p_io_idle; !io_hit |-> io_rdata == 8'h00; endproperty
    a_io_idle: assert property (p_io_idle) else $error("io data without hit");
    property p_cfg_idle; !$past(cfg_rd) |-> cfg_rdata == 8'h00; endproperty
    a_cfg_idle: assert property (p_cfg_idle) else $error("config data without read");
    property p_hi_nib; $past(cfg_rd && cfg_index == 8'h60) |-> cfg_rdata[7:4] == 4'h0; endproperty
    a_hi_nib: assert property (p_hi_nib) else $error("base high upper nibble set");
    property p_act_rd; $past(cfg_rd && cfg_index == 8'h30) |-> cfg_rdata == {7'h00, $past(act_reg)}; endproperty
    a_act_rd: assert property (p_act_rd) else $error("activate readback wrong");
    property p_wake; wake_event == (|pin_edge_event); endproperty
    a_wake: assert property (p_wake) else $error("wake not tied to edges");
    property p_edge;
        |pin_edge_event |->
            (pin_edge_event & ~($past(shared_host_pin_in[7:0], 3) ^ $past(shared_host_pin_in[7:0], 4))) == 8'h00;
    endproperty
    a_edge: assert property (p_edge) else $error("edge event without pin change");
endmodule
bind dhg_shared_gpio dhg_shared_gpio_checker dhg_shared_gpio_checker_inst (.sys_clk(sys_clk), .rst(rst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_rdata(io_rdata), .io_hit(io_hit),
    .shared_host_pin_in(shared_host_pin_in), .pin_edge_event(pin_edge_event), .wake_event(wake_event));
`default_nettype wire

// [dv/dhg_lpc_host_model.sv]
// host-side bus controller model: config and io cycles
`timescale 1ns/100ps
`default_nettype none
module dhg_lpc_host_model
(
    // clock
    input  wire logic        sys_clk,
    // config cycles
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [7:0]       cfg_index,
    output logic [7:0]       cfg_wdata,
    input  wire logic [7:0]  cfg_rdata,
    // io cycles
    output logic             io_wr,
    output logic             io_rd,
    output logic [15:0]      io_addr,
    output logic [7:0]       io_wdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_hit
);
    // idle bus; released lines show inverted values, not the last ones
    initial {cfg_wr, cfg_rd, cfg_index, cfg_wdata, io_wr, io_rd, io_addr, io_wdata} = '0;
    // base kept 16-byte aligned and below 0x1000 by the callers
    task automatic cfg_acc(input logic wr, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk); #1;
        {cfg_wr, cfg_rd, cfg_index, cfg_wdata} = {wr, !wr, i, d};
        @(posedge sys_clk); #1;
        q = cfg_rdata;
        {cfg_wr, cfg_rd, cfg_index, cfg_wdata} = {2'b00, ~i, ~d};
    endtask
    task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic h);
        @(posedge sys_clk); #1;
        {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, a, d};
        @(posedge sys_clk); #1;
        q = io_rdata;
        h = io_hit;
        {io_wr, io_rd, io_addr, io_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// [dv/dhg_shared_gpio_tb_top.sv]
// self-checking bench for the shared-pin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module dhg_shared_gpio_tb_top;
    typedef struct { logic own; logic pg; logic [7:0] hdir, hout, mdir, mout, oe, outm; } dhg_row_s;
    logic        sys_clk = 1'b0, rst = 1'b1, main_power_good = 1'b0, mc_wr = 1'b0, mc_rd = 1'b0;
    logic        cfg_wr, cfg_rd, io_wr, io_rd, io_hit, wake_event, h, seen;
    logic [3:0]  mc_addr = 4'h0;
    logic [7:0]  mc_wdata = 8'h00, cfg_index, cfg_wdata, cfg_rdata, io_wdata, io_rdata, mc_rdata, q, pin_edge_event;
    logic [15:0] io_addr;
    logic [23:0] pin_in = 24'h000000, pin_out, pin_oe;
    int          miscompares = 0, check_count = 0;
    dhg_row_s    rows[4] = '{'{1'b1, 1'b0, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00},
                             '{1'b1, 1'b1, 8'hF0, 8'hAA, 8'h0F, 8'h55, 8'hF0, 8'hA0},
                             '{1'b0, 1'b0, 8'hF0, 8'hAA, 8'h0F, 8'h55, 8'h0F, 8'h05},
                             '{1'b0, 1'b1, 8'hF0, 8'hAA, 8'h0F, 8'h55, 8'h0F, 8'h05}};
    always #5 sys_clk = ~sys_clk;
    dhg_lpc_host_model dhg_lpc_host_model_inst (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit));
    dhg_shared_gpio dhg_shared_gpio_inst (.sys_clk(sys_clk), .rst(rst), .main_power_good(main_power_good),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_hit(io_hit), .mc_wr(mc_wr), .mc_rd(mc_rd), .mc_addr(mc_addr), .mc_wdata(mc_wdata),
        .mc_rdata(mc_rdata), .shared_host_pin_in(pin_in), .shared_host_pin_out(pin_out),
        .shared_host_pin_oe(pin_oe), .pin_edge_event(pin_edge_event), .wake_event(wake_event));
    // micro register cycle, same timing as the host cycles
    task automatic mc_acc(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge sys_clk); #1;
        {mc_wr, mc_rd, mc_addr, mc_wdata} = {wr, !wr, a, d};
        @(posedge sys_clk); #1;
        r = mc_rdata;
        {mc_wr, mc_rd, mc_addr, mc_wdata} = {2'b00, ~a, ~d};
    endtask
    // bounded look for a group-zero pin0 event pulse
    task automatic wait_evt(output logic s);
        s = 1'b0;
        repeat (8)
        begin
            @(posedge sys_clk); #1;
            if (pin_edge_event[0] === 1'b1 && wake_event === 1'b1) s = 1'b1;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog so a hang still ends in the verdict
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'b0;
        dhg_lpc_host_model_inst.cfg_acc(0, 8'h30, 8'h00, q); `CHK("act_reset", 8'h00, q)
        dhg_lpc_host_model_inst.cfg_acc(0, 8'h61, 8'h00, q); `CHK("base_reset", 8'h00, q)
        dhg_lpc_host_model_inst.io_acc(0, 16'h0340, 8'h00, q, h); `CHK("hit_off", 1'b0, h)
        dhg_lpc_host_model_inst.cfg_acc(1, 8'h60, 8'hF3, q);
        dhg_lpc_host_model_inst.cfg_acc(1, 8'h61, 8'h40, q);
        dhg_lpc_host_model_inst.cfg_acc(1, 8'h30, 8'h01, q);
        dhg_lpc_host_model_inst.cfg_acc(0, 8'h60, 8'h00, q); `CHK("base_high", 8'h03, q)
        dhg_lpc_host_model_inst.cfg_acc(0, 8'h61, 8'h00, q); `CHK("base_low", 8'h40, q)
        dhg_lpc_host_model_inst.io_acc(0, 16'h0349, 8'h00, q, h); `CHK("hit_off9", 1'b1, h)
        `CHK("data_off9", 8'h00, q)
        dhg_lpc_host_model_inst.io_acc(0, 16'h1340, 8'h00, q, h); `CHK("hit_range", 1'b0, h)
        $display("test config done");
        // owner and power table on group two
        foreach (rows[i])
        begin
            main_power_good = rows[i].pg;
            mc_acc(1, 4'h0, {5'h00, rows[i].own, 2'b00}, q);
            mc_acc(1, 4'h3, rows[i].mdir, q);
            mc_acc(1, 4'h6, rows[i].mout, q);
            dhg_lpc_host_model_inst.io_acc(1, 16'h0346, rows[i].hdir, q, h);
            dhg_lpc_host_model_inst.io_acc(1, 16'h0348, rows[i].hout, q, h);
            repeat (4) @(posedge sys_clk);
            #1 `CHK("grp2_oe", rows[i].oe, pin_oe[23:16])
            `CHK("grp2_out", rows[i].outm, pin_out[23:16] & pin_oe[23:16])
        end
        dhg_lpc_host_model_inst.io_acc(0, 16'h0348, 8'h00, q, h); `CHK("host_out_rd", 8'hAA, q)
        mc_acc(0, 4'h6, 8'h00, q); `CHK("mc_out_rd", 8'h55, q)
        $display("test owner table done");
        pin_in = 24'h5AC3A5;
        repeat (3) @(posedge sys_clk);
        mc_acc(0, 4'h7, 8'h00, q); `CHK("mc_in0", 8'hA5, q)
        mc_acc(0, 4'h9, 8'h00, q); `CHK("mc_in2", 8'h5A, q)
        dhg_lpc_host_model_inst.io_acc(0, 16'h0344, 8'h00, q, h); `CHK("host_in1", 8'hC3, q)
        dhg_lpc_host_model_inst.io_acc(1, 16'h0344, 8'hFF, q, h);
        dhg_lpc_host_model_inst.io_acc(0, 16'h0344, 8'h00, q, h); `CHK("host_in_ro", 8'hC3, q)
        mc_acc(0, 4'h0, 8'h00, q); `CHK("owner_kept", 8'h00, q)
        $display("test inputs done");
        pin_in[0] = 1'b0;
        wait_evt(seen); `CHK("fall_evt", 1'b1, seen)
        pin_in[0] = 1'b1;
        wait_evt(seen); `CHK("rise_evt", 1'b1, seen)
        mc_acc(1, 4'h1, 8'h01, q);
        pin_in[0] = 1'b0;
        wait_evt(seen); `CHK("out_no_evt", 1'b0, seen)
        $display("test edges done");
        mc_acc(1, 4'hA, 8'h01, q);
        mc_acc(1, 4'h4, 8'h01, q);
        repeat (3) @(posedge sys_clk);
        #1 `CHK("od_high_oe", 1'b0, pin_oe[0])
        mc_acc(1, 4'h4, 8'h00, q);
        repeat (3) @(posedge sys_clk);
        #1 `CHK("od_low_oe", 1'b1, pin_oe[0])
        `CHK("od_low_out", 1'b0, pin_out[0])
        $display("test open drain done");
        // mid-run reset with group zero pins at 8'hA4, some held high: no false edge may follow
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge sys_clk); #1;
            if (wake_event !== 1'b0) seen = 1'b1;
        end
        `CHK("reset_no_evt", 1'b0, seen)
        `CHK("reset_oe", 24'h000000, pin_oe)
        dhg_lpc_host_model_inst.cfg_acc(0, 8'h30, 8'h00, q); `CHK("act_mid_reset", 8'h00, q)
        $display("test mid reset done");
        complete_run();
    end
endmodule
`default_nettype wire
